/* File: shared/asr_pkg.sv */
// shared constants and types of the address-space and register-file decoder
package asr_pkg;
  localparam logic [15:0] RESET_START_ADDR = 16'h0100;
  localparam logic [15:0] OPT_BASE_ADDR = 16'h003c;
  localparam logic [15:0] VECTOR_LAST_ADDR = 16'h00ff;
  localparam logic [1:0] OPT_IDX_BOOT_HI = 2'h0;
  localparam logic [1:0] OPT_IDX_BOOT_LO = 2'h1;
  localparam logic [1:0] OPT_IDX_ISP = 2'h2;
  localparam logic [1:0] OPT_IDX_LVR = 2'h3;
  localparam logic [7:0] OPT_DEFAULT = 8'hff;
  localparam int ROM_KB_DEFAULT = 16;
  localparam logic [7:0] PAGE_SEL_ADDR = 8'hdf;
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  localparam logic [7:0] SLICE_A_ADDR = 8'hd6;
  localparam logic [7:0] SLICE_B_ADDR = 8'hd7;
  localparam logic [7:0] SLICE_A_RESET = 8'hc0;
  localparam logic [7:0] SLICE_B_RESET = 8'hc8;
  localparam logic [7:0] SET1_BASE = 8'hc0;
  localparam logic [7:0] BANK_BASE = 8'he0;
  localparam logic [7:0] LCD_LAST = 8'h0f;
  localparam logic [7:0] UNMAPPED_DATA = 8'hff;
  localparam logic [3:0] LCD_PAGE_DEFAULT = 4'h2;
  localparam int PAGES_DEFAULT = 2;
  localparam logic [9:0] SET1_INDEX = 10'h200;
  localparam logic [9:0] BANK1_INDEX = 10'h240;
  localparam logic [9:0] LCD_INDEX = 10'h260;
  localparam int RAM_DEPTH = 1024;
  localparam int BOOT_CYCLES = 8;

  typedef enum logic [1:0] {
    ASR_MODE_REG,
    ASR_MODE_INDIRECT,
    ASR_MODE_INDEXED,
    ASR_MODE_WORKING
  } asr_mode_t;
endpackage : asr_pkg

/* File: verilog/asr_mem.sv */
// small synchronous memory with a registered read port
module asr_mem
  import asr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  // the array itself cannot live in the state struct; only the read register does
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdData_d;
  logic [WIDTH-1:0] rdData_q;

  always_comb begin
    rdData_d = rdData_q;
    if (rdEn) begin
      rdData_d = mem[rdAddr];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (!reset_n) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign rdData = rdData_q;
endmodule : asr_mem

/* File: verilog/asr_boot.sv */
// start-up sequencer: reads the option bytes and settles the start address
module asr_boot
  import asr_pkg::*;
#(
  parameter bit FULL_FLASH = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  output logic [15:0] romAddr,
  output logic romRead,
  input wire logic [7:0] romRdata,
  output logic bootDone,
  output logic [15:0] resetStartAddr,
  output logic [7:0] ispOption,
  output logic [7:0] lvrOption
);
  typedef enum logic [1:0] {BT_ISSUE, BT_CAPTURE, BT_DONE} asr_boot_st_t;
  typedef struct packed {
    asr_boot_st_t st;
    logic [1:0] idx;
    logic [3:0][7:0] opt;
    logic [15:0] start;
  } asr_boot_t;

  asr_boot_t s_q;
  asr_boot_t s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      BT_ISSUE: begin
        s_d.st = BT_CAPTURE;
      end
      BT_CAPTURE: begin
        s_d.opt[s_q.idx] = romRdata;
        if (s_q.idx == OPT_IDX_LVR) begin
          s_d.st = BT_DONE;
          // only the full-flash part lets the options move the start address
          if (FULL_FLASH && s_q.opt[OPT_IDX_ISP] != OPT_DEFAULT) begin
            s_d.start = {s_q.opt[OPT_IDX_BOOT_HI], s_q.opt[OPT_IDX_BOOT_LO]};
          end else begin
            s_d.start = RESET_START_ADDR;
          end
        end else begin
          s_d.idx = s_q.idx + 2'h1;
          s_d.st = BT_ISSUE;
        end
      end
      BT_DONE: begin
        s_d.st = BT_DONE;
      end
      default: begin
        s_d.st = BT_ISSUE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_q.st <= BT_ISSUE;
      s_q.idx <= '0;
      s_q.opt <= {4{OPT_DEFAULT}};
      s_q.start <= RESET_START_ADDR;
    end else begin
      s_q <= s_d;
    end
  end

  assign romRead = (s_q.st == BT_ISSUE);
  assign romAddr = OPT_BASE_ADDR + {14'h0, s_q.idx};
  assign bootDone = (s_q.st == BT_DONE);
  assign resetStartAddr = s_q.start;
  // other variants ignore whatever the programmer left there
  assign ispOption = FULL_FLASH ? s_q.opt[OPT_IDX_ISP] : OPT_DEFAULT;
  assign lvrOption = s_q.opt[OPT_IDX_LVR];
endmodule : asr_boot

/* File: verilog/asr_decoder.sv */
// program-memory and register-file address decoder
//
// Overview of operation
// - program fetch uses its own 16-bit address
// - register address and data on 8-bit bus
// - rom size 16, 8 or 4 KB, exact decode
// - 256 physical bytes seen as 320 by mode
// - vector area 0-FFH fetchable as normal code
// - fetch starts at 0100H after reset
// - only full-flash part may move start address
// - start options read from rom 003CH-003FH
// - low-voltage-reset option byte honoured everywhere
// - top 64 bytes exist twice: set 1, 2
// - set 1 upper half banked, lower common
// - set 1 reached on any page, register mode
// - control, lcd, peripheral and general storage provided
// - page select register at DFH picks pages
// - low nibble source, high destination, reset zero
// - lcd data bytes live on their own page
// - reset selects bank 0
// - C0H-FFH indirect or indexed reaches set 2
// - slice pointers reset to C0H and C8H
module asr_decoder
  import asr_pkg::*;
#(
  parameter int ROM_KB = ROM_KB_DEFAULT,
  parameter int PAGES = PAGES_DEFAULT,
  parameter logic [3:0] LCD_PAGE = LCD_PAGE_DEFAULT,
  parameter bit FULL_FLASH = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [15:0] progAddr,
  input wire logic progRead,
  output logic progReady,
  output logic [7:0] progData,
  output logic progValid,
  input wire logic romLoadWrite,
  input wire logic [15:0] romLoadAddr,
  input wire logic [7:0] romLoadData,
  input wire logic [7:0] regAddr,
  input wire asr_mode_t regMode,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regRvalid,
  input wire logic selectBankZeroOp,
  input wire logic selectBankOneOp,
  output logic [15:0] resetStartAddr,
  output logic bootDone,
  output logic [7:0] inSystemProgrammingOption,
  output logic [7:0] lowVoltageResetOption,
  output logic [7:0] registerPageSelect,
  output logic bankSelect
);
  localparam int ROM_BYTES = ROM_KB * 1024;
  localparam int ROM_AW = $clog2(ROM_BYTES);
  localparam int RAM_AW = $clog2(RAM_DEPTH);

  typedef struct packed {
    logic [7:0] pageSel;
    logic bank;
    logic [7:0] sliceA;
    logic [7:0] sliceB;
    logic regValid;
    logic useLocal;
    logic [7:0] localData;
    logic progValid;
    logic progMiss;
  } asr_dec_state_t;

  asr_dec_state_t s_q;
  asr_dec_state_t s_d;

  logic [15:0] bootRomAddr;
  logic bootRomRead;
  logic [7:0] romRdata;
  logic [7:0] ramRdata;
  logic romInRange;
  logic [ROM_AW-1:0] romRdAddr;
  logic romRdEn;
  logic [7:0] effAddr;
  asr_mode_t effMode;
  logic [10:0] rdMap;
  logic [10:0] wrMap;
  logic localHit;

  // {hit, index} of a register byte in the physical store
  function automatic logic [10:0] mapAddr(input logic [7:0] a, input logic [3:0] pg,
                                           input logic bank, input asr_mode_t m);
    logic [9:0] idx;
    logic hit;
    idx = '0;
    hit = 1'b0;
    if (a >= SET1_BASE && m == ASR_MODE_REG) begin
      hit = 1'b1;
      if (a >= BANK_BASE && bank) begin
        idx = BANK1_INDEX + {2'h0, a - BANK_BASE};
      end else begin
        idx = SET1_INDEX + {2'h0, a - SET1_BASE};
      end
    end else if (32'(pg) < PAGES) begin
      // prime area and set 2 of each implemented page; at most two pages fit
      hit = 1'b1;
      idx = {1'b0, pg[0], a};
    end else if (pg == LCD_PAGE && a <= LCD_LAST) begin
      hit = 1'b1;
      idx = LCD_INDEX + {6'h0, a[3:0]};
    end
    return {hit, idx};
  endfunction : mapAddr

  // working mode folds the register number onto a slice pointer
  always_comb begin
    effAddr = regAddr;
    effMode = regMode;
    if (regMode == ASR_MODE_WORKING) begin
      effAddr = regAddr[3] ? {s_q.sliceB[7:3], regAddr[2:0]} : {s_q.sliceA[7:3], regAddr[2:0]};
      effMode = ASR_MODE_REG;
    end
  end

  assign rdMap = mapAddr(effAddr, s_q.pageSel[3:0], s_q.bank, effMode);
  assign wrMap = mapAddr(effAddr, s_q.pageSel[7:4], s_q.bank, effMode);
  assign localHit = (effMode == ASR_MODE_REG) &&
                    (effAddr == PAGE_SEL_ADDR || effAddr == SLICE_A_ADDR || effAddr == SLICE_B_ADDR);

  // rom is shared with the start-up sequencer until it finishes
  assign romInRange = 32'(progAddr) < ROM_BYTES;
  assign romRdAddr = bootDone ? progAddr[ROM_AW-1:0] : bootRomAddr[ROM_AW-1:0];
  assign romRdEn = bootDone ? (progRead && romInRange) : bootRomRead;

  always_comb begin
    s_d = s_q;
    s_d.regValid = regRead;
    s_d.progValid = progRead && bootDone;
    if (progRead && bootDone) begin
      s_d.progMiss = !romInRange;
    end
    if (selectBankZeroOp) begin
      s_d.bank = 1'b0;
    end else if (selectBankOneOp) begin
      s_d.bank = 1'b1;
    end
    if (regRead) begin
      s_d.useLocal = 1'b1;
      if (localHit) begin
        case (effAddr)
          PAGE_SEL_ADDR: s_d.localData = s_q.pageSel;
          SLICE_A_ADDR: s_d.localData = s_q.sliceA;
          default: s_d.localData = s_q.sliceB;
        endcase
      end else if (rdMap[10]) begin
        s_d.useLocal = 1'b0;
      end else begin
        s_d.localData = UNMAPPED_DATA;
      end
    end
    if (regWrite && localHit) begin
      case (effAddr)
        PAGE_SEL_ADDR: s_d.pageSel = regWdata;
        SLICE_A_ADDR: s_d.sliceA = regWdata;
        default: s_d.sliceB = regWdata;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_q.pageSel <= PAGE_SEL_RESET;
      s_q.bank <= 1'b0;
      s_q.sliceA <= SLICE_A_RESET;
      s_q.sliceB <= SLICE_B_RESET;
      s_q.regValid <= 1'b0;
      s_q.useLocal <= 1'b1;
      s_q.localData <= UNMAPPED_DATA;
      s_q.progValid <= 1'b0;
      s_q.progMiss <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  asr_boot #(
    .FULL_FLASH(FULL_FLASH)
  ) u_boot (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .romAddr(bootRomAddr),
    .romRead(bootRomRead),
    .romRdata(romRdata),
    .bootDone(bootDone),
    .resetStartAddr(resetStartAddr),
    .ispOption(inSystemProgrammingOption),
    .lvrOption(lowVoltageResetOption)
  );

  asr_mem #(
    .WIDTH(8),
    .DEPTH(ROM_BYTES)
  ) u_rom (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wrEn(romLoadWrite && 32'(romLoadAddr) < ROM_BYTES),
    .wrAddr(romLoadAddr[ROM_AW-1:0]),
    .wrData(romLoadData),
    .rdEn(romRdEn),
    .rdAddr(romRdAddr),
    .rdData(romRdata)
  );

  // one store holds both pages, set 1 with its banks and the lcd page
  asr_mem #(
    .WIDTH(8),
    .DEPTH(RAM_DEPTH)
  ) u_ram (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wrEn(regWrite && wrMap[10] && !localHit),
    .wrAddr(wrMap[RAM_AW-1:0]),
    .wrData(regWdata),
    .rdEn(regRead && rdMap[10]),
    .rdAddr(rdMap[RAM_AW-1:0]),
    .rdData(ramRdata)
  );

  assign progReady = bootDone;
  assign progData = s_q.progMiss ? UNMAPPED_DATA : romRdata;
  assign progValid = s_q.progValid;
  assign regRdata = s_q.useLocal ? s_q.localData : ramRdata;
  assign regRvalid = s_q.regValid;
  assign registerPageSelect = s_q.pageSel;
  assign bankSelect = s_q.bank;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_fetch_req;
    progRead && bootDone;
  endsequence

  sequence s_reset_pulse;
    !reset_n ##1 reset_n;
  endsequence

  property p_fetch_answer;
    s_fetch_req |=> progValid;
  endproperty
  a_fetch_answer: assert property (p_fetch_answer) else $error("fetch not answered");

  property p_fetch_beyond_rom;
    s_fetch_req and !romInRange |=> progData == UNMAPPED_DATA;
  endproperty
  a_fetch_beyond_rom: assert property (p_fetch_beyond_rom) else $error("fetch outside rom not fixed");

  property p_vector_fetch;
    s_fetch_req and progAddr <= VECTOR_LAST_ADDR |=> !s_q.progMiss;
  endproperty
  a_vector_fetch: assert property (p_vector_fetch) else $error("vector area not fetchable");

  property p_reg_answer;
    regRead |=> regRvalid;
  endproperty
  a_reg_answer: assert property (p_reg_answer) else $error("register read not answered");

  property p_boot_time;
    disable iff (1'b0) s_reset_pulse |-> !bootDone [*8] ##1 bootDone;
  endproperty
  a_boot_time: assert property (p_boot_time) else $error("option read did not finish in time");

  property p_fixed_start;
    bootDone && !FULL_FLASH |-> resetStartAddr == RESET_START_ADDR;
  endproperty
  a_fixed_start: assert property (p_fixed_start) else $error("start address moved on fixed part");

  property p_isp_ignored;
    !FULL_FLASH |-> inSystemProgrammingOption == OPT_DEFAULT;
  endproperty
  a_isp_ignored: assert property (p_isp_ignored) else $error("isp option not ignored");

  property p_reset_state;
    disable iff (1'b0) !reset_n |=> registerPageSelect == PAGE_SEL_RESET && !bankSelect
      && s_q.sliceA == SLICE_A_RESET && s_q.sliceB == SLICE_B_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_bank_one;
    selectBankOneOp && !selectBankZeroOp |=> bankSelect;
  endproperty
  a_bank_one: assert property (p_bank_one) else $error("bank one not selected");

  property p_page_write;
    regWrite && regMode == ASR_MODE_REG && regAddr == PAGE_SEL_ADDR |=>
      registerPageSelect == $past(regWdata);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page select not written");

  property p_unmapped_read;
    regRead && !localHit && !rdMap[10] |=> regRdata == UNMAPPED_DATA;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not fixed");

  property p_set2_route;
    regMode == ASR_MODE_INDIRECT && regAddr >= SET1_BASE && 32'(s_q.pageSel[3:0]) < PAGES |->
      rdMap[9:8] != 2'h2;
  endproperty
  a_set2_route: assert property (p_set2_route) else $error("indirect access reached set 1");

  property p_fetch_refused;
    progRead && !bootDone |=> !progValid;
  endproperty
  a_fetch_refused: assert property (p_fetch_refused) else $error("fetch answered before options loaded");

  property p_fetch_idle;
    !progRead |=> !progValid;
  endproperty
  a_fetch_idle: assert property (p_fetch_idle) else $error("fetch answer without request");

  property p_reg_idle;
    !regRead |=> !regRvalid;
  endproperty
  a_reg_idle: assert property (p_reg_idle) else $error("register answer without request");

  // zero wins when both ops arrive together
  property p_bank_zero;
    selectBankZeroOp |=> !bankSelect;
  endproperty
  a_bank_zero: assert property (p_bank_zero) else $error("bank zero not selected");

  property p_bank_hold;
    !selectBankZeroOp && !selectBankOneOp |=> $stable(bankSelect);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("bank moved without an op");

  property p_page_hold;
    !(regWrite && localHit && effAddr == PAGE_SEL_ADDR) |=> $stable(registerPageSelect);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page select moved without a write");

  property p_boot_stays;
    bootDone |=> bootDone;
  endproperty
  a_boot_stays: assert property (p_boot_stays) else $error("option load restarted without reset");

  property p_lcd_range;
    regRead && regMode == ASR_MODE_REG && regAddr < SET1_BASE && regAddr > LCD_LAST &&
      s_q.pageSel[3:0] == LCD_PAGE |=> regRdata == UNMAPPED_DATA;
  endproperty
  a_lcd_range: assert property (p_lcd_range) else $error("lcd page read beyond its bytes");
endmodule : asr_decoder

/* File: sim/asr_cpu_model.sv */
// cpu-side model: rom preload, fetches, register accesses and bank ops
module asr_cpu_model
  import asr_pkg::*;
(
  input wire logic clk_sys,
  output logic [15:0] progAddr,
  output logic progRead,
  input wire logic progValid,
  input wire logic [7:0] progData,
  output logic romLoadWrite,
  output logic [15:0] romLoadAddr,
  output logic [7:0] romLoadData,
  output logic [7:0] regAddr,
  output asr_mode_t regMode,
  output logic regRead,
  output logic regWrite,
  output logic [7:0] regWdata,
  input wire logic regRvalid,
  input wire logic [7:0] regRdata,
  output logic selectBankZeroOp,
  output logic selectBankOneOp
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    progAddr = 16'h0000;
    progRead = 1'b0;
    romLoadWrite = 1'b0;
    romLoadAddr = 16'h0000;
    romLoadData = 8'h00;
    regAddr = 8'h00;
    regMode = ASR_MODE_REG;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWdata = 8'h00;
    selectBankZeroOp = 1'b0;
    selectBankOneOp = 1'b0;
  end

  // caller keeps the isp byte erased on parts without full flash
  task automatic rom_load(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    romLoadWrite <= 1'b1;
    romLoadAddr <= a;
    romLoadData <= d;
    @(posedge clk_sys);
    romLoadWrite <= 1'b0;
    romLoadData <= ~d;
  endtask : rom_load

  // released lines carry the inverse, so a stale value never passes
  task automatic fetch(input logic [15:0] a, output logic v, output logic [7:0] d);
    @(posedge clk_sys);
    progRead <= 1'b1;
    progAddr <= a;
    @(posedge clk_sys);
    progRead <= 1'b0;
    progAddr <= ~a;
    #1;
    v = progValid;
    d = progData;
  endtask : fetch

  task automatic reg_rd(input logic [7:0] a, input asr_mode_t m, output logic v, output logic [7:0] d);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    regMode <= m;
    @(posedge clk_sys);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    v = regRvalid;
    d = regRdata;
  endtask : reg_rd

  task automatic reg_wr(input logic [7:0] a, input asr_mode_t m, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regMode <= m;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
    #1;
  endtask : reg_wr

  task automatic bank_op(input logic one);
    @(posedge clk_sys);
    selectBankZeroOp <= ~one;
    selectBankOneOp <= one;
    @(posedge clk_sys);
    selectBankZeroOp <= 1'b0;
    selectBankOneOp <= 1'b0;
    #1;
  endtask : bank_op
endmodule : asr_cpu_model

/* File: sim/address_space_register_file_map_tb.sv */
// self-checking bench of the address-space and register-file decoder
module address_space_register_file_map_tb
  import asr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic progRead, progReady, progValid, romLoadWrite, regRead, regWrite, regRvalid;
  logic selectBankZeroOp, selectBankOneOp, bootDone, bankSelect, v;
  logic [15:0] progAddr, romLoadAddr, resetStartAddr;
  logic [7:0] progData, romLoadData, regAddr, regWdata, regRdata, d;
  logic [7:0] inSystemProgrammingOption, lowVoltageResetOption, registerPageSelect;
  asr_mode_t regMode;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  asr_decoder i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .progAddr(progAddr), .progRead(progRead),
    .progReady(progReady), .progData(progData), .progValid(progValid), .romLoadWrite(romLoadWrite),
    .romLoadAddr(romLoadAddr), .romLoadData(romLoadData), .regAddr(regAddr), .regMode(regMode),
    .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .selectBankZeroOp(selectBankZeroOp), .selectBankOneOp(selectBankOneOp), .resetStartAddr(resetStartAddr),
    .bootDone(bootDone), .inSystemProgrammingOption(inSystemProgrammingOption),
    .lowVoltageResetOption(lowVoltageResetOption), .registerPageSelect(registerPageSelect),
    .bankSelect(bankSelect));

  asr_cpu_model i_cpu (.clk_sys(clk_sys), .progAddr(progAddr), .progRead(progRead), .progValid(progValid),
    .progData(progData), .romLoadWrite(romLoadWrite), .romLoadAddr(romLoadAddr), .romLoadData(romLoadData),
    .regAddr(regAddr), .regMode(regMode), .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata),
    .regRvalid(regRvalid), .regRdata(regRdata), .selectBankZeroOp(selectBankZeroOp),
    .selectBankOneOp(selectBankOneOp));

  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk16

  task automatic chk1(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic rd_chk(input logic [7:0] a, input asr_mode_t m, input logic [7:0] e);
    i_cpu.reg_rd(a, m, v, d);
    chk1("read valid", 1'b1, v);
    chk16("read data", {8'h00, e}, {8'h00, d});
  endtask : rd_chk

  task automatic fe_chk(input logic [15:0] a, input logic [7:0] e);
    i_cpu.fetch(a, v, d);
    chk1("fetch valid", 1'b1, v);
    chk16("fetch data", {8'h00, e}, {8'h00, d});
  endtask : fe_chk

  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // generous ceiling, the whole sequence needs under 150 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      give_verdict();
    end
  end

  initial begin
    i_cpu.rom_load(16'h003c, 8'h12);
    i_cpu.rom_load(16'h003d, 8'h34);
    i_cpu.rom_load(16'h003e, 8'hff);
    i_cpu.rom_load(16'h003f, 8'h5a);
    i_cpu.rom_load(16'h0005, 8'ha5);
    i_cpu.rom_load(16'h0100, 8'hc3);
    i_cpu.rom_load(16'h3fff, 8'h7e);
    i_cpu.rom_load(16'h4000, 8'h5c);
    repeat (2) @(posedge clk_sys);
    #1;
    chk1("ready in reset", 1'b0, progReady);
    chk16("page select", 16'h0000, {8'h00, registerPageSelect});
    chk1("bank", 1'b0, bankSelect);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    i_cpu.fetch(16'h0100, v, d);
    chk1("early fetch", 1'b0, v);
    rd_chk(SLICE_A_ADDR, ASR_MODE_REG, 8'hc0);
    rd_chk(SLICE_B_ADDR, ASR_MODE_REG, 8'hc8);
    for (int i = 0; i < 20 && bootDone !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk1("boot done", 1'b1, bootDone);
    chk16("lvr option", 16'h005a, {8'h00, lowVoltageResetOption});
    chk16("isp option", 16'h00ff, {8'h00, inSystemProgrammingOption});
    chk16("start", 16'h0100, resetStartAddr);
    fe_chk(16'h0005, 8'ha5);
    fe_chk(16'h0100, 8'hc3);
    fe_chk(16'h3fff, 8'h7e);
    fe_chk(16'h4000, 8'hff);
    // paged area: source nibble for reads, destination nibble for writes
    i_cpu.reg_wr(8'h80, ASR_MODE_REG, 8'ha1);
    i_cpu.reg_wr(PAGE_SEL_ADDR, ASR_MODE_REG, 8'h11);
    chk16("page select", 16'h0011, {8'h00, registerPageSelect});
    i_cpu.reg_wr(8'h80, ASR_MODE_REG, 8'hb2);
    rd_chk(8'h80, ASR_MODE_REG, 8'hb2);
    i_cpu.reg_wr(PAGE_SEL_ADDR, ASR_MODE_REG, 8'h01);
    i_cpu.reg_wr(8'h80, ASR_MODE_REG, 8'hc4);
    rd_chk(8'h80, ASR_MODE_REG, 8'hb2);
    i_cpu.reg_wr(PAGE_SEL_ADDR, ASR_MODE_REG, 8'h00);
    rd_chk(8'h80, ASR_MODE_REG, 8'hc4);
    // same address, set 1 against set 2 by mode
    i_cpu.reg_wr(8'hc5, ASR_MODE_REG, 8'h11);
    i_cpu.reg_wr(8'hc5, ASR_MODE_INDIRECT, 8'h22);
    rd_chk(8'hc5, ASR_MODE_REG, 8'h11);
    rd_chk(8'hc5, ASR_MODE_INDEXED, 8'h22);
    rd_chk(8'hc5, ASR_MODE_INDIRECT, 8'h22);
    i_cpu.reg_wr(PAGE_SEL_ADDR, ASR_MODE_REG, 8'h11);
    rd_chk(8'hc5, ASR_MODE_REG, 8'h11);
    i_cpu.reg_wr(PAGE_SEL_ADDR, ASR_MODE_REG, 8'h00);
    i_cpu.reg_wr(8'he5, ASR_MODE_REG, 8'h33);
    i_cpu.bank_op(1'b1);
    chk1("bank", 1'b1, bankSelect);
    i_cpu.reg_wr(8'he5, ASR_MODE_REG, 8'h44);
    rd_chk(8'he5, ASR_MODE_REG, 8'h44);
    rd_chk(8'hc5, ASR_MODE_REG, 8'h11);
    i_cpu.bank_op(1'b0);
    chk1("bank", 1'b0, bankSelect);
    rd_chk(8'he5, ASR_MODE_REG, 8'h33);
    // lcd page, then an unimplemented page
    i_cpu.reg_wr(PAGE_SEL_ADDR, ASR_MODE_REG, 8'h22);
    i_cpu.reg_wr(8'h05, ASR_MODE_REG, 8'h55);
    rd_chk(8'h05, ASR_MODE_REG, 8'h55);
    rd_chk(8'h10, ASR_MODE_REG, UNMAPPED_DATA);
    i_cpu.reg_wr(PAGE_SEL_ADDR, ASR_MODE_REG, 8'h33);
    i_cpu.reg_wr(8'h80, ASR_MODE_REG, 8'h99);
    rd_chk(8'h80, ASR_MODE_REG, UNMAPPED_DATA);
    i_cpu.reg_wr(PAGE_SEL_ADDR, ASR_MODE_REG, 8'h00);
    rd_chk(8'h80, ASR_MODE_REG, 8'hc4);
    // working mode through the reset pointer values
    i_cpu.reg_wr(8'hc0, ASR_MODE_REG, 8'h66);
    i_cpu.reg_wr(8'hc9, ASR_MODE_REG, 8'h77);
    rd_chk(8'h00, ASR_MODE_WORKING, 8'h66);
    rd_chk(8'h09, ASR_MODE_WORKING, 8'h77);
    // moved pointer a folds r0 onto the prime area of page 0
    i_cpu.reg_wr(SLICE_A_ADDR, ASR_MODE_REG, 8'h80);
    rd_chk(SLICE_A_ADDR, ASR_MODE_REG, 8'h80);
    rd_chk(8'h00, ASR_MODE_WORKING, 8'hc4);
    give_verdict();
  end
endmodule : address_space_register_file_map_tb
